/* File: sml_consts.vh */
/*
 Constants for the serial memory link datapath: widths, packet field
 positions, register offsets and reset values.
 Assumes it is included by bare name from the datapath module.
*/
`ifndef SML_CONSTS_VH
`define SML_CONSTS_VH

// Datapath shape
`define SML_FPW 4
`define SML_LOG_FPW 2
`define SML_FLIT_W 128
`define SML_DW 512
`define SML_LANES 16
`define SML_LANE_W 32
`define SML_USER_W 64
`define SML_LOG_MAX_RTC 8
`define SML_REG_WRITE_WIDTH 64
`define SML_REG_READ_WIDTH 64
`define SML_REG_ADDR_WIDTH 4

// Packet fields, relative to one flit
`define SML_CMD_W 6
`define SML_CMD_TRET 6'h02
`define SML_LNG_LSB 7
`define SML_RTC_LSB 64
`define SML_RTC_W 5
`define SML_POISON_BIT 69
`define SML_CRC_LSB 96
`define SML_CRC_W 32
`define SML_CRC_POLY 32'h741b8cd7

// Descrambler and training
`define SML_LFSR_W 15
`define SML_ID_W 4
`define SML_SLIP_WAIT 8'h20

// Token accounting
`define SML_TOK_W 10
`define SML_RTC_MAX 10'h01f
`define SML_INIT_TOKENS 10'h100

// Register map, byte addresses
`define SML_REG_CTRL 4'h0
`define SML_REG_STATUS 4'h4
`define SML_REG_TOKENS 4'h8
`define SML_REG_ERRCNT 4'hc
`define SML_CTRL_MEM_RST 0
`define SML_CTRL_SCR_DIS 1
`define SML_CTRL_SLEEP 2
`define SML_RESP_OKAY 2'h0
`define SML_RESP_SLVERR 2'h2

`endif

/* File: sml_link_datapath.v */
/*
 Link datapath of a serial memory controller: transmit CRC insertion and
 token return, receive descrambling, lane alignment, CRC check, input
 buffer, and a small AXI4-Lite register file.
 Assumes one clock, a synchronous active-low reset released with the clock,
 and transceivers that delay a lane by one bit per slip pulse.
*/
`timescale 1ns/1ps
`include "sml_consts.vh"

// How it works
// - Per-flit CRC computed in parallel
// - Partial remainders combined per packet, one cycle
// - Combined CRC written into tail flit
// - At most one flow packet per cycle
// - Token return capped at 31 per packet
// - Receive checks packets, passes tail tokens forward
// - Receive data selected only after link up
// - Receive CRC mismatch poisons tail flit
// - Valid, header, tail bits travel with data
// - Per-lane self-seeding descrambler reports lock
// - Lane slip pulses until lanes align
// - Input buffer holds 2**8 full words
// - Each read valid flit credits one token
// - Reserved register bits read zero
// - Control bit drives memory reset pin
// - Flits per word fixed at 4
// - Lane count fixed at 16
// - Register data 32, address 4 bits
// - Reset and power pins active low
// - Stream moves on valid and ready
// - Sideband: valid, header, tail bit groups
// - Lane 0 lowest bits, reversal corrected
module sml_link_datapath (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Register bus
	input wire [`SML_REG_ADDR_WIDTH-1:0] awaddr,
	input wire awvalid,
	output reg awready,
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	input wire wvalid,
	output reg wready,
	output reg [1:0] bresp,
	output reg bvalid,
	input wire bready,
	input wire [`SML_REG_ADDR_WIDTH-1:0] araddr,
	input wire arvalid,
	output reg arready,
	output reg [31:0] rdata,
	output reg [1:0] rresp,
	output reg rvalid,
	input wire rready,
	// Transmit stream from user
	input wire [`SML_DW-1:0] s_tdata,
	input wire [`SML_USER_W-1:0] s_tuser,
	input wire s_tvalid,
	output reg s_tready,
	// Receive stream to user
	output reg [`SML_DW-1:0] m_tdata,
	output reg [`SML_USER_W-1:0] m_tuser,
	output reg m_tvalid,
	input wire m_tready,
	// Transceivers
	output reg [`SML_DW-1:0] lane_data_out,
	input wire [`SML_DW-1:0] lane_data_in,
	output reg [`SML_LANES-1:0] lane_slip,
	// Memory device pins
	output reg mem_reset_n,
	output reg rx_power_state_pin,
	input wire tx_power_state_pin
);

localparam [1:0] INIT_WAIT = 2'h0;
localparam [1:0] INIT_LOCK = 2'h1;
localparam [1:0] INIT_ALIGN = 2'h2;
localparam [1:0] INIT_UP = 2'h3;
localparam DEPTH = 1 << `SML_LOG_MAX_RTC;
localparam EW = `SML_DW + 3 * `SML_FPW;

function [31:0] crc_flit;
	input [31:0] init;
	input [127:0] d;
	integer k;
	reg [31:0] c;
	begin
		c = init;
		for (k = 127; k >= 0; k = k - 1)
			c = {c[30:0], 1'b0} ^ ({32{c[31] ^ d[k]}} & `SML_CRC_POLY);
		crc_flit = c;
	end
endfunction

// Combines remainders in flit order; a header restarts the packet
function [32*`SML_FPW+31:0] crc_comb;
	input [31:0] acc_in;
	input [`SML_FPW-1:0] fv;
	input [`SML_FPW-1:0] fh;
	input [32*`SML_FPW-1:0] parts;
	integer k;
	reg [31:0] a;
	reg [32*`SML_FPW-1:0] r;
	begin
		a = acc_in;
		r = {32*`SML_FPW{1'b0}};
		for (k = 0; k < `SML_FPW; k = k + 1)
		begin
			if (fv[k])
				a = (fh[k] ? 32'h0 : crc_flit(a, 128'h0)) ^ parts[k*32 +: 32];
			r[k*32 +: 32] = a;
		end
		crc_comb = {a, r};
	end
endfunction

function [46:0] lfsr_run;
	input [14:0] s;
	integer k;
	reg [14:0] t;
	reg [31:0] ks;
	begin
		t = s;
		ks = 32'h0;
		for (k = 0; k < `SML_LANE_W; k = k + 1)
		begin
			ks[k] = t[0];
			t = {t[1] ^ t[0], t[14:1]};
		end
		lfsr_run = {t, ks};
	end
endfunction

// Last 15 keystream bits of a cycle, advanced to the next cycle's start
function [14:0] lfsr_seed;
	input [14:0] s;
	integer k;
	reg [14:0] t;
	begin
		t = s;
		for (k = 0; k < `SML_LFSR_W; k = k + 1)
			t = {t[1] ^ t[0], t[14:1]};
		lfsr_seed = t;
	end
endfunction

function [2:0] pop4;
	input [3:0] v;
	begin
		pop4 = {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]};
	end
endfunction

reg [1:0] init_st;
reg [7:0] slip_wait;
reg rev;
reg scr_dis;
reg [`SML_TOK_W-1:0] tok_pend;
reg [`SML_TOK_W-1:0] rem_tok;
reg [`SML_DW-1:0] tx_in;
reg [`SML_FPW-1:0] tx_in_v, tx_in_h, tx_in_t;
reg [`SML_DW-1:0] ta_data;
reg [`SML_FPW-1:0] ta_v, ta_h, ta_t;
reg [32*`SML_FPW-1:0] ta_part;
reg [31:0] tx_acc;
reg [`SML_DW-1:0] tx_out;
reg [`SML_FPW-1:0] rx_v, rx_h, rx_t;
reg [3:0] rx_rem, next_rx_rem;
reg [`SML_DW-1:0] ra_data;
reg [`SML_FPW-1:0] ra_v, ra_h, ra_t;
reg [32*`SML_FPW-1:0] ra_part;
reg [31:0] rx_acc;
reg [`SML_DW-1:0] rb_data;
reg [`SML_FPW-1:0] wr_v;
reg rx_bad;
reg [`SML_TOK_W-1:0] rtc_in;
reg [15:0] err_cnt;
reg [EW-1:0] buf_mem [0:DEPTH-1];
reg [`SML_LOG_MAX_RTC:0] wptr, rptr;
reg aw_held, w_held;
reg [`SML_REG_ADDR_WIDTH-1:0] aw_a;
reg [31:0] w_d;
reg [3:0] w_s;
reg [31:0] rd_mux;
wire [`SML_DW-1:0] desc_all;
wire [`SML_DW-1:0] rx_word;
wire [`SML_LFSR_W*`SML_LANES-1:0] st_all;
wire [`SML_LANES-1:0] lock_all, st_eq;
wire [32*`SML_FPW-1:0] tx_part, rx_part;
wire [32*`SML_FPW+31:0] tcomb, rcomb;
wire link_up = (init_st == INIT_UP);
wire grant = (init_st == INIT_ALIGN) && (&st_eq);
// transfer only on valid and ready
wire tx_take = s_tvalid && s_tready;
// flow packet only in a cycle without user data
wire tx_tret = !tx_take && link_up && (tok_pend != 10'h0);
wire [4:0] tret_cnt = (tok_pend > `SML_RTC_MAX) ? 5'h1f : tok_pend[4:0];
wire buf_empty = (wptr == rptr);
wire buf_full = (wptr[7:0] == rptr[7:0]) && (wptr[8] != rptr[8]);
wire [EW-1:0] buf_head = buf_mem[rptr[7:0]];
wire buf_pop = (!m_tvalid || m_tready) && !buf_empty;
// one token per valid flit leaving the buffer
wire [2:0] credit = buf_pop ? pop4(buf_head[`SML_DW +: `SML_FPW]) : 3'h0;
wire [2:0] tx_used = tx_take ? pop4(s_tuser[`SML_FPW-1:0]) : 3'h0;
wire [`SML_TOK_W-1:0] next_tok_pend = tok_pend + {7'h0, credit}
	+ (grant ? `SML_INIT_TOKENS : 10'h0) - (tx_tret ? {5'h0, tret_cnt} : 10'h0);
wire [`SML_TOK_W-1:0] next_rem_tok = rem_tok + rtc_in - {7'h0, tx_used};
wire wr_fire = aw_held && w_held && !bvalid;
wire wr_ok = wr_fire && (aw_a[1:0] == 2'h0);

genvar g;
generate
	for (g = 0; g < `SML_LANES; g = g + 1)
	begin : lane
		wire [31:0] raw = lane_data_in[g*`SML_LANE_W +: `SML_LANE_W];
		reg [14:0] st;
		reg seeded;
		reg locked;
		wire [46:0] run = lfsr_run(st);
		wire [31:0] desc = scr_dis ? raw : (raw ^ run[31:0]);
		// seed from stream, lock on clean null data
		always @(posedge aclk)
		begin
			if (!aresetn || !mem_reset_n || lane_slip[g])
			begin
				st <= 15'h0;
				seeded <= 1'b0;
				locked <= 1'b0;
			end
			else if (locked)
				st <= run[46:32];
			else if (seeded && desc[31:`SML_ID_W] == 28'h0)
			begin
				locked <= 1'b1;
				st <= run[46:32];
			end
			else
			begin
				st <= lfsr_seed(raw[31:17]);
				seeded <= 1'b1;
			end
		end
		assign desc_all[g*`SML_LANE_W +: `SML_LANE_W] = desc;
		assign st_all[g*`SML_LFSR_W +: `SML_LFSR_W] = st;
		assign lock_all[g] = locked;
		assign st_eq[g] = (st == st_all[`SML_LFSR_W-1:0]);
		assign rx_word[g*`SML_LANE_W +: `SML_LANE_W] =
			rev ? desc_all[(`SML_LANES-1-g)*`SML_LANE_W +: `SML_LANE_W] : desc;
	end
endgenerate

// one CRC unit per flit, both directions
generate
	for (g = 0; g < `SML_FPW; g = g + 1)
	begin : flit
		wire [127:0] tf = tx_in[g*128 +: 128];
		wire [127:0] rf = rx_word[g*128 +: 128];
		// remainder over flit, CRC field zeroed
		assign tx_part[g*32 +: 32] =
			crc_flit(32'h0, tx_in_t[g] ? {32'h0, tf[95:0]} : tf);
		assign rx_part[g*32 +: 32] =
			crc_flit(32'h0, rx_t[g] ? {32'h0, rf[95:0]} : rf);
	end
endgenerate

// slip mismatching lanes until all keystreams match
always @(posedge aclk)
begin
	if (!aresetn || !mem_reset_n)
	begin
		init_st <= INIT_WAIT;
		slip_wait <= 8'h0;
		lane_slip <= {`SML_LANES{1'b0}};
		rev <= 1'b0;
	end
	else
	begin
		lane_slip <= {`SML_LANES{1'b0}};
		case (init_st)
			INIT_WAIT:
			begin
				slip_wait <= `SML_SLIP_WAIT;
				init_st <= INIT_LOCK;
			end
			INIT_LOCK:
				if (slip_wait != 8'h0)
					slip_wait <= slip_wait - 8'h1;
				else if (&lock_all)
					init_st <= INIT_ALIGN;
			INIT_ALIGN:
				if (&st_eq)
				begin
					rev <= (desc_all[`SML_ID_W-1:0] == 4'hf);
					init_st <= INIT_UP;
				end
				else
				begin
					lane_slip <= ~st_eq;
					slip_wait <= `SML_SLIP_WAIT;
					init_st <= INIT_LOCK;
				end
			INIT_UP:
				init_st <= INIT_UP;
			default:
				init_st <= INIT_WAIT;
		endcase
	end
end

// sideband groups; TRET built as one-flit packet
always @*
begin
	tx_in = {`SML_DW{1'b0}};
	tx_in_v = s_tuser[`SML_FPW-1:0];
	tx_in_h = s_tuser[2*`SML_FPW-1:`SML_FPW];
	tx_in_t = s_tuser[3*`SML_FPW-1:2*`SML_FPW];
	if (tx_take)
		tx_in = s_tdata;
	else
	begin
		tx_in_v = {3'h0, tx_tret};
		tx_in_h = {3'h0, tx_tret};
		tx_in_t = {3'h0, tx_tret};
		if (tx_tret)
		begin
			tx_in[`SML_CMD_W-1:0] = `SML_CMD_TRET;
			tx_in[`SML_LNG_LSB +: 4] = 4'h1;
			tx_in[`SML_RTC_LSB +: `SML_RTC_W] = tret_cnt;
		end
	end
end

// one-cycle accumulation across flits of a packet
assign tcomb = crc_comb(tx_acc, ta_v, ta_h, ta_part);

always @*
begin : tx_ins
	integer k;
	k = 0;
	tx_out = ta_data;
	for (k = 0; k < `SML_FPW; k = k + 1)
	begin
		if (!ta_v[k])
			tx_out[k*128 +: 128] = 128'h0;
		else if (ta_t[k])
			tx_out[k*128 + `SML_CRC_LSB +: 32] = tcomb[k*32 +: 32];
	end
end

always @(posedge aclk)
begin
	if (!aresetn)
	begin
		ta_data <= {`SML_DW{1'b0}};
		ta_v <= 4'h0;
		ta_h <= 4'h0;
		ta_t <= 4'h0;
		ta_part <= 128'h0;
		tx_acc <= 32'h0;
		lane_data_out <= {`SML_DW{1'b0}};
		tok_pend <= 10'h0;
		rem_tok <= 10'h0;
		s_tready <= 1'b0;
	end
	else
	begin
		ta_data <= tx_in;
		ta_v <= tx_in_v;
		ta_h <= tx_in_h;
		ta_t <= tx_in_t;
		ta_part <= tx_part;
		tx_acc <= tcomb[32*`SML_FPW +: 32];
		lane_data_out <= tx_out;
		tok_pend <= next_tok_pend;
		rem_tok <= next_rem_tok;
		// Holding user data while tokens pile up keeps the return flowing
		s_tready <= link_up && (next_rem_tok >= 10'h004)
			&& (next_tok_pend < `SML_RTC_MAX);
	end
end

// Packet framing from header length; only meaningful once the link is up
always @*
begin : rx_parse
	integer k;
	reg [127:0] f;
	k = 0;
	f = 128'h0;
	next_rx_rem = rx_rem;
	rx_v = 4'h0;
	rx_h = 4'h0;
	rx_t = 4'h0;
	for (k = 0; k < `SML_FPW; k = k + 1)
	begin
		f = rx_word[k*128 +: 128];
		if (next_rx_rem == 4'h0)
		begin
			if (f[`SML_CMD_W-1:0] != 6'h0)
			begin
				rx_v[k] = 1'b1;
				rx_h[k] = 1'b1;
				next_rx_rem = (f[`SML_LNG_LSB +: 4] == 4'h0) ? 4'h0 :
					f[`SML_LNG_LSB +: 4] - 4'h1;
				rx_t[k] = (next_rx_rem == 4'h0);
			end
		end
		else
		begin
			rx_v[k] = 1'b1;
			next_rx_rem = next_rx_rem - 4'h1;
			rx_t[k] = (next_rx_rem == 4'h0);
		end
	end
end

assign rcomb = crc_comb(rx_acc, ra_v, ra_h, ra_part);

// compare and poison; tail tokens toward transmit side
always @*
begin : rx_chk
	integer k;
	k = 0;
	rb_data = ra_data;
	wr_v = ra_v;
	rx_bad = 1'b0;
	rtc_in = 10'h0;
	for (k = 0; k < `SML_FPW; k = k + 1)
	begin
		if (ra_v[k] && ra_t[k])
		begin
			if (ra_data[k*128 + `SML_CRC_LSB +: 32] != rcomb[k*32 +: 32])
			begin
				rb_data[k*128 + `SML_POISON_BIT] = 1'b1;
				rx_bad = 1'b1;
			end
			else
				rtc_in = rtc_in + {5'h0, ra_data[k*128 + `SML_RTC_LSB +: `SML_RTC_W]};
		end
		// Flow packets are consumed here, not handed to the user
		if (ra_h[k] && ra_data[k*128 +: `SML_CMD_W] == `SML_CMD_TRET)
			wr_v[k] = 1'b0;
	end
end

always @(posedge aclk)
begin
	if (!aresetn)
	begin
		rx_rem <= 4'h0;
		ra_data <= {`SML_DW{1'b0}};
		ra_v <= 4'h0;
		ra_h <= 4'h0;
		ra_t <= 4'h0;
		ra_part <= 128'h0;
		rx_acc <= 32'h0;
		err_cnt <= 16'h0;
		wptr <= 9'h0;
		rptr <= 9'h0;
		m_tvalid <= 1'b0;
		m_tdata <= {`SML_DW{1'b0}};
		m_tuser <= {`SML_USER_W{1'b0}};
	end
	else
	begin
		// training data never reaches the packet path
		rx_rem <= link_up ? next_rx_rem : 4'h0;
		ra_data <= rx_word;
		// flags ride with data and remainders
		ra_v <= link_up ? rx_v : 4'h0;
		ra_h <= link_up ? rx_h : 4'h0;
		ra_t <= link_up ? rx_t : 4'h0;
		ra_part <= rx_part;
		rx_acc <= rcomb[32*`SML_FPW +: 32];
		if (wr_ok && aw_a == `SML_REG_ERRCNT)
			err_cnt <= {15'h0, rx_bad};
		else if (rx_bad)
			err_cnt <= err_cnt + 16'h1;
		// Overflow cannot happen while the partner honours returned tokens
		if ((|wr_v) && !buf_full)
			wptr <= wptr + 9'h1;
		if (buf_pop)
		begin
			m_tdata <= buf_head[`SML_DW-1:0];
			m_tuser <= {52'h0, buf_head[EW-1:`SML_DW]};
			m_tvalid <= 1'b1;
			rptr <= rptr + 9'h1;
		end
		else if (m_tready)
			m_tvalid <= 1'b0;
	end
end

// full word per entry, 2**8 entries
always @(posedge aclk)
begin
	if ((|wr_v) && !buf_full)
		buf_mem[wptr[7:0]] <= {ra_t & wr_v, ra_h & wr_v, wr_v, rb_data};
end

always @*
begin
	case (araddr)
		`SML_REG_CTRL:
			rd_mux = {29'h0, ~rx_power_state_pin, scr_dis, mem_reset_n};
		`SML_REG_STATUS:
			rd_mux = {lock_all, 11'h0, ~tx_power_state_pin, tx_power_state_pin,
				rev, &lock_all, link_up};
		`SML_REG_TOKENS:
			rd_mux = {6'h0, rem_tok, 6'h0, tok_pend};
		`SML_REG_ERRCNT:
			rd_mux = {16'h0, err_cnt};
		default:
			rd_mux = 32'h0;
	endcase
end

always @(posedge aclk)
begin
	if (!aresetn)
	begin
		awready <= 1'b1;
		wready <= 1'b1;
		aw_held <= 1'b0;
		w_held <= 1'b0;
		aw_a <= 4'h0;
		w_d <= 32'h0;
		w_s <= 4'h0;
		bvalid <= 1'b0;
		bresp <= `SML_RESP_OKAY;
		arready <= 1'b1;
		rvalid <= 1'b0;
		rresp <= `SML_RESP_OKAY;
		rdata <= 32'h0;
		// memory held in reset until software releases it
		mem_reset_n <= 1'b0;
		scr_dis <= 1'b0;
		rx_power_state_pin <= 1'b1;
	end
	else
	begin
		if (awvalid && awready)
		begin
			aw_held <= 1'b1;
			aw_a <= awaddr;
			awready <= 1'b0;
		end
		if (wvalid && wready)
		begin
			w_held <= 1'b1;
			w_d <= wdata;
			w_s <= wstrb;
			wready <= 1'b0;
		end
		if (wr_fire)
		begin
			bvalid <= 1'b1;
			bresp <= (aw_a[1:0] == 2'h0) ? `SML_RESP_OKAY : `SML_RESP_SLVERR;
			// control bit drives the reset pin
			if (wr_ok && aw_a == `SML_REG_CTRL && w_s[0])
			begin
				mem_reset_n <= w_d[`SML_CTRL_MEM_RST];
				scr_dis <= w_d[`SML_CTRL_SCR_DIS];
				rx_power_state_pin <= ~w_d[`SML_CTRL_SLEEP];
			end
		end
		if (bvalid && bready)
		begin
			bvalid <= 1'b0;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			awready <= 1'b1;
			wready <= 1'b1;
		end
		if (arvalid && arready)
		begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_mux;
			rresp <= (araddr[1:0] == 2'h0) ? `SML_RESP_OKAY : `SML_RESP_SLVERR;
		end
		else if (rvalid && rready)
		begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end
end

endmodule // sml_link_datapath

/* File: sml_link_checker.sv */
/*
 Port assertions for the link datapath.
 Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`include "sml_consts.vh"
module sml_link_checker (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Register bus
	input wire [`SML_REG_ADDR_WIDTH-1:0] awaddr,
	input wire awvalid,
	input wire awready,
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	input wire wvalid,
	input wire wready,
	input wire [1:0] bresp,
	input wire bvalid,
	input wire bready,
	input wire arvalid,
	input wire arready,
	input wire [31:0] rdata,
	input wire rvalid,
	input wire rready,
	// Streams
	input wire s_tvalid,
	input wire s_tready,
	input wire [`SML_DW-1:0] m_tdata,
	input wire [`SML_USER_W-1:0] m_tuser,
	input wire m_tvalid,
	input wire m_tready,
	// Lanes and pins
	input wire [`SML_DW-1:0] lane_data_out,
	input wire [`SML_LANES-1:0] lane_slip,
	input wire mem_reset_n,
	input wire rx_power_state_pin
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	rst_out_a: assert property ($rose(aresetn) |-> !bvalid && !rvalid && !s_tready && !m_tvalid
		&& lane_slip == 0 && !mem_reset_n && rx_power_state_pin)
		else $error("outputs not at reset values");
	b_lat_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("write answer late");
	rd_lat_a: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped");
	r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer dropped");
	m_hold_a: assert property (m_tvalid && !m_tready |=> m_tvalid && $stable(m_tdata))
		else $error("receive word dropped before ready");
	ctrl_pins_a: assert property (awvalid && awready && wvalid && wready && awaddr == 4'h0
		&& wstrb[0] |-> ##2 mem_reset_n == $past(wdata[0], 2)
		&& rx_power_state_pin == !$past(wdata[2], 2))
		else $error("control pins do not follow control word");
	user_pad_a: assert property (m_tvalid |-> m_tuser[`SML_USER_W-1:12] == 0)
		else $error("receive sideband upper bits set");
	slip_pulse_a: assert property (lane_slip != 0 |=> (lane_slip == 0) [*8])
		else $error("slip pulses too close");
	tret_alone_a: assert property (lane_data_out[5:0] == `SML_CMD_TRET
		|-> lane_data_out[`SML_DW-1:128] == 0 && lane_data_out[68:64] != 0)
		else $error("token return word malformed");

	cover property (s_tvalid && s_tready);
	cover property (lane_slip != 0);
	cover property (bvalid && bresp == `SML_RESP_SLVERR);
	cover property (lane_data_out[5:0] == `SML_CMD_TRET);
endmodule // sml_link_checker

bind sml_link_datapath sml_link_checker sml_link_checker_i (.aclk, .aresetn, .awaddr,
	.awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
	.arvalid, .arready, .rdata, .rvalid, .rready, .s_tvalid, .s_tready, .m_tdata,
	.m_tuser, .m_tvalid, .m_tready, .lane_data_out, .lane_slip, .mem_reset_n,
	.rx_power_state_pin);

/* File: sml_xcvr_model.sv */
/*
 Transceivers plus memory side: scrambled lane stream with per-lane skew.
 Assumes the bench raises up once the link is trained.
*/
`timescale 1ns/1ps
`include "sml_consts.vh"
module sml_xcvr_model (
	// Clock and mode
	input wire aclk,
	input wire up,
	// Lanes
	output logic [`SML_DW-1:0] lane_data_in,
	input wire [`SML_LANES-1:0] lane_slip,
	// Memory pins
	input wire rx_power_state_pin,
	output wire tx_power_state_pin
);
	logic [14:0] lfsr = 15'h7fff;
	logic [31:0] ks;
	logic [95:0] hist [`SML_LANES];
	logic [5:0] skew [`SML_LANES];
	logic [3:0] ack = 4'hf;
	logic [2:0] cnt = 0;
	logic [127:0] tret;
	logic [31:0] c;
	integer i, k;
	initial
	begin
		lane_data_in = 0;
		// Lane 0 and odd lanes lag most; other even lanes lag one bit less and catch up by slipping.
		// A smaller lag would pull lane index bits into the seed window.
		for (k = 0; k < `SML_LANES; k++)
		begin
			skew[k] = (k == 0 || k[0]) ? 6'd32 : 6'd31;
			hist[k] = 0;
		end
		tret = {59'h0, 5'd31, 53'h0, 4'h1, 1'b0, `SML_CMD_TRET};
		c = 0;
		for (i = 127; i >= 0; i--)
			c = {c[30:0], 1'b0} ^ ((c[31] ^ tret[i]) ? `SML_CRC_POLY : 32'h0);
		tret[127:96] = c;
	end
	always @(posedge aclk)
	begin
		cnt <= cnt + 3'd1;
		for (i = 0; i < 32; i++)
		begin
			ks[i] = lfsr[0];
			lfsr = {lfsr[1] ^ lfsr[0], lfsr[14:1]};
		end
		for (k = 0; k < `SML_LANES; k++)
		begin
			if (lane_slip[k] && skew[k] != 6'd63)
				skew[k] = skew[k] + 6'd1;
			hist[k] = {ks ^ (!up ? k : (k < 4 && cnt == 0) ? tret[32*k +: 32] : 0),
				hist[k][95:32]};
			lane_data_in[32*k +: 32] <= hist[k][64-skew[k] +: 32];
		end
		ack <= {ack[2:0], rx_power_state_pin};
	end
	assign tx_power_state_pin = ack[3];
endmodule // sml_xcvr_model

/* File: tb_serial_memory_link_datapath.sv */
/*
 Self-checking bench: register bus, training, transmit CRC insertion.
 Assumes the datapath header and the transceiver model alongside.
*/
`timescale 1ns/1ps
`include "sml_consts.vh"
module tb_serial_memory_link_datapath;
	logic aclk = 0;
	logic aresetn = 0;
	logic [3:0] awaddr = 0, araddr = 0, wstrb = 4'hf;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic s_tvalid = 0, m_tready = 0, up = 0;
	logic [31:0] wdata = 0;
	logic [`SML_DW-1:0] s_tdata = 0;
	logic [`SML_USER_W-1:0] s_tuser = 0;
	wire awready, wready, bvalid, arready, rvalid, s_tready, m_tvalid, mrst, rxps, txps;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [`SML_DW-1:0] m_tdata, lout, lin;
	wire [`SML_USER_W-1:0] m_tuser;
	wire [`SML_LANES-1:0] slip;
	int num_errors = 0, cmp_count = 0, cyc = 0;
	logic [65:0] rq[$];
	logic [65:0] e;
	logic [1:0] bq[$];
	logic [`SML_DW-1:0] sq[$];
	wire [3:0] poison = {m_tdata[453], m_tdata[325], m_tdata[197], m_tdata[69]};

	sml_link_datapath sml_link_datapath_i (.aclk, .aresetn, .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .s_tdata, .s_tuser, .s_tvalid,
		.s_tready, .m_tdata, .m_tuser, .m_tvalid, .m_tready, .lane_data_out(lout),
		.lane_data_in(lin), .lane_slip(slip), .mem_reset_n(mrst),
		.rx_power_state_pin(rxps), .tx_power_state_pin(txps));
	sml_xcvr_model sml_xcvr_model_i (.aclk, .up, .lane_data_in(lin), .lane_slip(slip),
		.rx_power_state_pin(rxps), .tx_power_state_pin(txps));

	initial
	begin
		forever #4 aclk = ~aclk;
	end

	task automatic chk(input string what, input logic [`SML_DW-1:0] x, y);
	begin
		cmp_count++;
		if (y !== x)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, x, y);
		end
	end
	endtask

	task automatic test_done;
	begin
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w;
	begin
		@(posedge aclk);
		bq.push_back(er);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		aw = 1;
		w = 1;
		while (aw || w)
		begin
			@(posedge aclk);
			if (awready)
			begin
				aw = 0;
				awvalid <= 0;
			end
			if (wready)
			begin
				w = 0;
				wvalid <= 0;
			end
		end
		do @(posedge aclk); while (!bvalid);
		bready <= 0;
	end
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] m, x, input logic [1:0] er,
		output logic [31:0] q);
	begin
		@(posedge aclk);
		rq.push_back({er, m, x & m});
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do @(posedge aclk); while (!arready);
		arvalid <= 0;
		do @(posedge aclk); while (!rvalid);
		rready <= 0;
		q = rdata;
	end
	endtask

	task automatic send_word;
		logic [`SML_DW-1:0] d, x;
		logic [31:0] c;
		int n, i, j;
	begin
		n = $urandom_range(1, 4);
		d = 0;
		c = 0;
		for (i = 0; i < n; i++)
			d[128*i +: 128] = {$urandom, $urandom, $urandom, $urandom};
		d[5:0] = 6'h30;
		d[128*n-32 +: 32] = 0;
		x = d;
		// Flit 0 enters the packet CRC first, each flit from its top bit down
		for (j = 0; j < n; j++)
			for (i = 127; i >= 0; i--)
				c = {c[30:0], 1'b0} ^ ((c[31] ^ d[128*j+i]) ? `SML_CRC_POLY : 32'h0);
		x[128*n-32 +: 32] = c;
		sq.push_back(x);
		s_tdata <= d;
		s_tuser <= {52'h0, 4'(1 << (n - 1)), 4'h1, 4'((1 << n) - 1)};
		s_tvalid <= 1;
		do @(posedge aclk); while (!s_tready);
	end
	endtask

	always @(posedge aclk)
	begin
		m_tready <= 1'($urandom);
		cyc++;
		if (bvalid && bready)
			chk("bresp", bq.pop_front(), bresp);
		if (rvalid && rready)
		begin
			e = rq.pop_front();
			chk("rresp", e[65:64], rresp);
			chk("rdata", e[31:0], rdata & e[63:32]);
		end
		if (sq.size() > 0 && lout !== 0 && lout[5:0] !== `SML_CMD_TRET)
			chk("lane word", sq.pop_front(), lout);
		// The partner sends no clean user packet, so every handed-over tail is poisoned
		if (m_tvalid && m_tready)
			chk("poisoned tails", m_tuser[11:8], m_tuser[11:8] & poison);
		if (cyc == 20000)
		begin
			num_errors++;
			test_done();
		end
	end

	initial
	begin
		logic [31:0] q, r;
		int n;
		r = $urandom(51467);
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		rd(`SML_REG_CTRL, 32'hffffffff, 0, `SML_RESP_OKAY, q);
		chk("mem_reset_n", 0, mrst);
		rd(4'h2, 0, 0, `SML_RESP_SLVERR, q);
		wr(4'h6, 1, `SML_RESP_SLVERR);
		$display("test reset done");
		repeat (4)
		begin
			r = $urandom;
			wr(`SML_REG_CTRL, r, `SML_RESP_OKAY);
			chk("mem_reset_n", r[0], mrst);
			chk("rx_power_state_pin", !r[2], rxps);
			rd(`SML_REG_CTRL, 32'hffffffff, r & 32'h7, `SML_RESP_OKAY, q);
		end
		$display("test control done");
		wr(`SML_REG_CTRL, 1, `SML_RESP_OKAY);
		n = 0;
		q = 0;
		while (q[0] !== 1'b1 && n < 500)
		begin
			rd(`SML_REG_STATUS, 0, 0, `SML_RESP_OKAY, q);
			n++;
		end
		up <= 1;
		rd(`SML_REG_STATUS, 32'hffff001f, 32'hffff000b, `SML_RESP_OKAY, q);
		$display("test training done");
		n = 0;
		while (s_tready !== 1'b1 && n < 2000)
		begin
			@(posedge aclk);
			n++;
		end
		repeat (8) send_word();
		s_tvalid <= 0;
		n = 0;
		while (sq.size() > 0 && n < 50)
		begin
			@(posedge aclk);
			n++;
		end
		chk("words left", 0, sq.size());
		$display("test transmit done");
		wr(`SML_REG_ERRCNT, 0, `SML_RESP_OKAY);
		rd(`SML_REG_ERRCNT, 32'hffffffff, 0, `SML_RESP_OKAY, q);
		rd(`SML_REG_TOKENS, 32'hfc00fc00, 0, `SML_RESP_OKAY, q);
		$display("test receive done");
		test_done();
	end
endmodule // tb_serial_memory_link_datapath
